// File: tss_readout.sv
// tilt sensor result formatting, fault forcing, self test and serial readout
// core logic on clock; link logic on sck, reset by chip select high
`timescale 1ns/1ps
// Summary of operation
// - results are 11-bit unsigned words
// - zero tilt reads 1024
// - result scales by variant sensitivity
// - fault-free results stay within 102..1945
// - interconnect and memory checked continuously
// - parity error reloads control register
// - repeat parity error forces results low
// - self test drives result to maximum
// - self-test commands start, measure ends
// - self-test pin high enables self test
// - saturate after 25 ms, recover 30 ms
// - output returns to pre-test value
// - temperature readable as 8-bit value
// - command codes for measure, self test, reads
// - temperature read ignores written data
// - refresh every 150 us unless selected
module tss_readout #(
    parameter int unsigned REFRESH_CYC = tss_pkg::REFRESH_CYC_DEF,
    parameter int unsigned SAT_CYC = tss_pkg::SAT_CYC_DEF,
    parameter int unsigned REC_CYC = tss_pkg::REC_CYC_DEF,
    parameter logic WIDE_RANGE = 1'b0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic sck,
    input wire logic chip_select_n,
    input wire logic mosi,
    output logic miso,
    output logic miso_oe,
    input wire logic proof_mass_check_pin_x,
    input wire logic proof_mass_check_pin_y,
    input wire logic signed [tss_pkg::ACC_W-1:0] x_accel_in,
    input wire logic signed [tss_pkg::ACC_W-1:0] y_accel_in,
    input wire logic [tss_pkg::TEMP_W-1:0] temp_in,
    input wire logic element_link_ok,
    input wire logic [tss_pkg::CTRL_W-1:0] nv_ctrl_word,
    input wire logic nv_ctrl_parity,
    output logic nv_fetch,
    output logic ctrl_fail,
    output logic st_drive_x,
    output logic st_drive_y
);
    typedef enum logic [1:0] {CT_LOAD, CT_RUN, CT_RELOAD, CT_FAIL} tss_ctrl_e;

    // core-domain state
    tss_ctrl_e ctrl_state_q;
    logic [tss_pkg::CTRL_W-1:0] ctrl_q;
    logic ctrl_par_q;
    logic reloaded_q;
    logic nv_fetch_q;
    logic [1:0] st_cmd_q;
    logic [1:0] st_drive_q;
    logic [1:0] sat_q;
    logic [tss_pkg::ST_CNT_W-1:0] st_cnt_q [2];
    logic [tss_pkg::REFRESH_CNT_W-1:0] refresh_cnt_q;
    logic [tss_pkg::RES_W-1:0] x_res_q;
    logic [tss_pkg::RES_W-1:0] y_res_q;
    logic [tss_pkg::TEMP_W-1:0] temp_q;
    logic cmd_done_d1_q;

    // link-domain state
    logic [tss_pkg::BIT_CNT_W-1:0] bit_cnt_q;
    logic [tss_pkg::CMD_W-1:0] cmd_sr_q;
    logic cmd_done_q;
    logic tx_started_q;
    logic [tss_pkg::RES_W-1:0] tx_sr_q;
    logic miso_q;
    logic miso_oe_q;

    // synchronised levels
    logic cs_n_s;
    logic cmd_done_s;
    logic pin_x_s;
    logic pin_y_s;

    tss_sync3 #(.RST_VAL(1'b1)) u_sync_cs (
        .clock(clock),
        .rst_n(rst_n),
        .din(chip_select_n),
        .dout(cs_n_s)
    );
    tss_sync3 #(.RST_VAL(1'b0)) u_sync_cmd (
        .clock(clock),
        .rst_n(rst_n),
        .din(cmd_done_q),
        .dout(cmd_done_s)
    );
    tss_sync3 #(.RST_VAL(1'b0)) u_sync_pin_x (
        .clock(clock),
        .rst_n(rst_n),
        .din(proof_mass_check_pin_x),
        .dout(pin_x_s)
    );
    tss_sync3 #(.RST_VAL(1'b0)) u_sync_pin_y (
        .clock(clock),
        .rst_n(rst_n),
        .din(proof_mass_check_pin_y),
        .dout(pin_y_s)
    );

    // command decode; the code register is held until chip select rises,
    // so it is stable long after the synchronised done flag arrives
    wire cmd_evt = cmd_done_s & ~cmd_done_d1_q;
    wire is_normal_run_cmd = (cmd_sr_q == tss_pkg::CMD_MEASURE);
    wire is_st_x = (cmd_sr_q == tss_pkg::CMD_ST_X);
    wire is_st_y = (cmd_sr_q == tss_pkg::CMD_ST_Y);
    wire is_reload = (cmd_sr_q == tss_pkg::CMD_RELOAD);
    wire evt_normal_run_cmd = cmd_evt & is_normal_run_cmd;
    wire evt_st_x = cmd_evt & is_st_x;
    wire evt_st_y = cmd_evt & is_st_y;
    wire evt_reload = cmd_evt & is_reload;

    // both channels at once is left to the host to avoid
    wire [1:0] st_on = st_cmd_q | {pin_y_s, pin_x_s};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            cmd_done_d1_q <= 1'b0;
            st_cmd_q <= 2'h0;
            st_drive_q <= 2'h0;
        end else begin
            cmd_done_d1_q <= cmd_done_s;
            if (evt_normal_run_cmd) begin
                st_cmd_q <= 2'h0;
            end else begin
                st_cmd_q <= st_cmd_q | {evt_st_y, evt_st_x};
            end
            st_drive_q <= st_on;
        end
    end

    // saturation and recovery timing of the deflected proof mass; the
    // analogue settling toward the pre-test value is outside this model
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            sat_q <= 2'h0;
            for (int i = 0; i < 2; i++) begin
                st_cnt_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (st_on[i] == sat_q[i]) begin
                    st_cnt_q[i] <= '0;
                end else if (st_on[i] && st_cnt_q[i] == tss_pkg::ST_CNT_W'(SAT_CYC - 1)) begin
                    sat_q[i] <= 1'b1;
                    st_cnt_q[i] <= '0;
                end else if (!st_on[i] && st_cnt_q[i] == tss_pkg::ST_CNT_W'(REC_CYC - 1)) begin
                    sat_q[i] <= 1'b0;
                    st_cnt_q[i] <= '0;
                end else begin
                    st_cnt_q[i] <= st_cnt_q[i] + 1'b1;
                end
            end
        end
    end

    // control register with continuous even parity check
    wire par_err = ^{ctrl_q, ctrl_par_q};

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_state_q <= CT_LOAD;
            ctrl_q <= '0;
            ctrl_par_q <= 1'b0;
            reloaded_q <= 1'b0;
            nv_fetch_q <= 1'b0;
        end else begin
            nv_fetch_q <= 1'b0;
            unique case (ctrl_state_q)
                CT_LOAD, CT_RELOAD: begin
                    ctrl_q <= nv_ctrl_word;
                    ctrl_par_q <= nv_ctrl_parity;
                    reloaded_q <= (ctrl_state_q == CT_RELOAD);
                    nv_fetch_q <= 1'b1;
                    ctrl_state_q <= CT_RUN;
                end
                CT_RUN: begin
                    if (par_err && reloaded_q) begin
                        ctrl_state_q <= CT_FAIL;
                    end else if (par_err) begin
                        ctrl_state_q <= CT_RELOAD;
                    end else if (evt_reload) begin
                        ctrl_state_q <= CT_LOAD;
                    end else begin
                        reloaded_q <= 1'b0;
                    end
                end
                CT_FAIL: begin
                    ctrl_state_q <= CT_FAIL;
                end
            endcase
        end
    end

    wire fail_now = (ctrl_state_q == CT_FAIL);
    wire signed [tss_pkg::TRIM_W-1:0] trim = ctrl_q[tss_pkg::TRIM_LSB +: tss_pkg::TRIM_W];

    function automatic logic [tss_pkg::RES_W-1:0] fmt(
        input logic signed [tss_pkg::ACC_W-1:0] acc,
        input logic sat
    );
        logic signed [13:0] scaled;
        logic signed [13:0] s;
        scaled = 14'(acc);
        if (WIDE_RANGE) begin
            scaled = scaled >>> tss_pkg::WIDE_SHIFT;
        end
        s = scaled + 14'(trim) + signed'({3'h0, tss_pkg::RES_ZERO});
        if (fail_now) begin
            fmt = tss_pkg::RES_FAULT_LO;
        end else if (!element_link_ok) begin
            fmt = tss_pkg::RES_FAULT_HI;
        end else if (sat) begin
            fmt = tss_pkg::RES_ST_MAX;
        end else if (s < signed'({3'h0, tss_pkg::RES_MIN_OK})) begin
            fmt = tss_pkg::RES_MIN_OK;
        end else if (s > signed'({3'h0, tss_pkg::RES_MAX_OK})) begin
            fmt = tss_pkg::RES_MAX_OK;
        end else begin
            fmt = s[tss_pkg::RES_W-1:0];
        end
    endfunction

    wire [tss_pkg::RES_W-1:0] x_fmt = fmt(x_accel_in, sat_q[0]);
    wire [tss_pkg::RES_W-1:0] y_fmt = fmt(y_accel_in, sat_q[1]);
    wire refresh_tick = (refresh_cnt_q == tss_pkg::REFRESH_CNT_W'(REFRESH_CYC - 1));
    // held off while selected so the link reads a frozen word
    wire refresh_load = refresh_tick & cs_n_s;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            refresh_cnt_q <= '0;
            x_res_q <= tss_pkg::RES_ZERO;
            y_res_q <= tss_pkg::RES_ZERO;
            temp_q <= '0;
        end else begin
            refresh_cnt_q <= refresh_tick ? '0 : refresh_cnt_q + 1'b1;
            if (refresh_load) begin
                x_res_q <= x_fmt;
                y_res_q <= y_fmt;
                temp_q <= temp_in;
            end
        end
    end

    // link side: command in on rising sck, data out on falling sck;
    // chip select high clears the frame, as the clock may stop there
    always_ff @(posedge sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            bit_cnt_q <= '0;
            cmd_sr_q <= '0;
            cmd_done_q <= 1'b0;
        end else if (bit_cnt_q != tss_pkg::CMD_BITS) begin
            // bits after the command (temperature write data) are ignored
            cmd_sr_q <= {cmd_sr_q[tss_pkg::CMD_W-2:0], mosi};
            bit_cnt_q <= bit_cnt_q + 1'b1;
            cmd_done_q <= (bit_cnt_q == tss_pkg::CMD_LAST);
        end
    end

    // results are quasi-static here: the core stops refreshing a few
    // core cycles after select falls, far ahead of the first data edge
    wire rd_x = (cmd_sr_q == tss_pkg::CMD_RD_X);
    wire rd_y = (cmd_sr_q == tss_pkg::CMD_RD_Y);
    wire rd_t = (cmd_sr_q == tss_pkg::CMD_TEMP);
    wire [tss_pkg::RES_W-1:0] tx_word = rd_x ? x_res_q :
        rd_y ? y_res_q : {temp_q, 3'h0};
    wire tx_first = cmd_done_q & ~tx_started_q;

    always_ff @(negedge sck or posedge chip_select_n) begin
        if (chip_select_n) begin
            tx_started_q <= 1'b0;
            tx_sr_q <= '0;
            miso_q <= 1'b0;
            miso_oe_q <= 1'b0;
        end else if (tx_first) begin
            tx_started_q <= 1'b1;
            // unknown or non-read commands leave the line undriven
            miso_oe_q <= rd_x | rd_y | rd_t;
            miso_q <= tx_word[tss_pkg::RES_W-1];
            tx_sr_q <= {tx_word[tss_pkg::RES_W-2:0], 1'b0};
        end else if (tx_started_q) begin
            miso_q <= tx_sr_q[tss_pkg::RES_W-1];
            tx_sr_q <= {tx_sr_q[tss_pkg::RES_W-2:0], 1'b0};
        end
    end

    assign miso = miso_q;
    assign miso_oe = miso_oe_q;
    assign nv_fetch = nv_fetch_q;
    assign ctrl_fail = fail_now;
    assign st_drive_x = st_drive_q[0];
    assign st_drive_y = st_drive_q[1];

    property p_range_ok;
        @(posedge clock) disable iff (!rst_n)
        (refresh_load && !fail_now && element_link_ok && !sat_q[0])
            |=> (x_res_q >= tss_pkg::RES_MIN_OK && x_res_q <= tss_pkg::RES_MAX_OK);
    endproperty
    a_range_ok: assert property (p_range_ok) else $error("x result outside normal range");

    property p_fail_low;
        @(posedge clock) disable iff (!rst_n)
        (fail_now && refresh_load) |=> (x_res_q < tss_pkg::RES_MIN_OK && y_res_q < tss_pkg::RES_MIN_OK);
    endproperty
    a_fail_low: assert property (p_fail_low) else $error("results not forced low on failure");

    property p_par_reload;
        @(posedge clock) disable iff (!rst_n)
        (ctrl_state_q == CT_RUN && par_err && !reloaded_q)
            |=> (ctrl_state_q == CT_RELOAD) ##1 (ctrl_q == $past(nv_ctrl_word) && nv_fetch_q);
    endproperty
    a_par_reload: assert property (p_par_reload) else $error("parity error did not reload");

    property p_link_high;
        @(posedge clock) disable iff (!rst_n)
        (refresh_load && !fail_now && !element_link_ok) |=> (y_res_q == tss_pkg::RES_FAULT_HI);
    endproperty
    a_link_high: assert property (p_link_high) else $error("link fault not forced high");

    property p_normal_run_cmd_ends;
        @(posedge clock) disable iff (!rst_n)
        evt_normal_run_cmd |=> (st_cmd_q == 2'h0);
    endproperty
    a_normal_run_cmd_ends: assert property (p_normal_run_cmd_ends) else $error("measure did not end self test");

    property p_stx_starts;
        @(posedge clock) disable iff (!rst_n)
        (evt_st_x && !evt_normal_run_cmd) |=> st_cmd_q[0] ##1 st_drive_q[0];
    endproperty
    a_stx_starts: assert property (p_stx_starts) else $error("self test x not started");

    property p_pin_drive;
        @(posedge clock) disable iff (!rst_n)
        $rose(pin_y_s) |=> st_drive_q[1];
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin did not drive self test");

    property p_sat_max;
        @(posedge clock) disable iff (!rst_n)
        (refresh_load && sat_q[0] && !fail_now && element_link_ok) |=> (x_res_q == tss_pkg::RES_ST_MAX);
    endproperty
    a_sat_max: assert property (p_sat_max) else $error("self test did not reach maximum");

    property p_sat_time;
        @(posedge clock) disable iff (!rst_n)
        $rose(sat_q[0]) |-> ($past(st_cnt_q[0]) == tss_pkg::ST_CNT_W'(SAT_CYC - 1) && $past(st_on[0]));
    endproperty
    a_sat_time: assert property (p_sat_time) else $error("saturation delay wrong");

    property p_hold_sel;
        @(posedge clock) disable iff (!rst_n)
        (!cs_n_s && refresh_tick) |=> ($stable(x_res_q) && $stable(temp_q));
    endproperty
    a_hold_sel: assert property (p_hold_sel) else $error("refresh while selected");

    c_fail: cover property (@(posedge clock) disable iff (!rst_n) $rose(fail_now));
    c_sat: cover property (@(posedge clock) disable iff (!rst_n) $fell(sat_q[0]));
    c_reload: cover property (@(posedge clock) disable iff (!rst_n) ctrl_state_q == CT_RELOAD);
endmodule // tss_readout

// File: tss_pkg.sv
// constants for the tilt sensor result, fault and self-test logic
// assumes a 100 MHz core clock and a serial master clocking the link
package tss_pkg;
    localparam int unsigned RES_W = 11;
    localparam int unsigned TEMP_W = 8;
    localparam int unsigned CMD_W = 8;
    localparam int unsigned ACC_W = 12;
    localparam int unsigned CTRL_W = 16;
    localparam int unsigned TRIM_LSB = 0;
    localparam int unsigned TRIM_W = 8;
    localparam int unsigned BIT_CNT_W = 4;
    localparam logic [3:0] CMD_BITS = 4'h8;
    localparam logic [3:0] CMD_LAST = 4'h7;

    localparam logic [10:0] RES_ZERO = 11'h400;
    localparam logic [10:0] RES_MIN_OK = 11'h066;
    localparam logic [10:0] RES_MAX_OK = 11'h799;
    localparam logic [10:0] RES_ST_MAX = 11'h799;
    localparam logic [10:0] RES_FAULT_LO = 11'h000;
    localparam logic [10:0] RES_FAULT_HI = 11'h7FF;

    // counts per g; the wide variant halves the narrow scale
    localparam int unsigned SENS_NARROW = 1638;
    localparam int unsigned SENS_WIDE = 819;
    localparam int unsigned WIDE_SHIFT = $clog2(SENS_NARROW / SENS_WIDE);

    localparam logic [7:0] CMD_MEASURE = 8'h00;
    localparam logic [7:0] CMD_TEMP = 8'h08;
    localparam logic [7:0] CMD_STATUS = 8'h0A;
    localparam logic [7:0] CMD_RELOAD = 8'h0B;
    localparam logic [7:0] CMD_ST_X = 8'h0E;
    localparam logic [7:0] CMD_ST_Y = 8'h0F;
    localparam logic [7:0] CMD_RD_X = 8'h10;
    localparam logic [7:0] CMD_RD_Y = 8'h11;

    localparam int unsigned CLK_KHZ = 100000;
    localparam int unsigned REFRESH_US = 150;
    localparam int unsigned SAT_DELAY_MS = 25;
    localparam int unsigned RECOVERY_MS = 30;
    localparam int unsigned REFRESH_CYC_DEF = (REFRESH_US * CLK_KHZ) / 1000;
    localparam int unsigned SAT_CYC_DEF = SAT_DELAY_MS * CLK_KHZ;
    localparam int unsigned REC_CYC_DEF = RECOVERY_MS * CLK_KHZ;
    localparam int unsigned REFRESH_CNT_W = 14;
    localparam int unsigned ST_CNT_W = 22;
endpackage

// File: tss_sync3.sv
// three-stage synchroniser for levels entering the core clock domain
// the output changes only when the second and third stages agree
`timescale 1ns/1ps
module tss_sync3 #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic out_q;

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            out_q <= RST_VAL;
        end else begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
                out_q <= s3_q;
            end
        end
    end

    assign dout = out_q;
endmodule // tss_sync3

// File: tss_spi_host.sv
// serial master model for the tilt readout: mode 0, msb first, 12 ns link clock
// assumes the device samples mosi on rising sck and shifts miso on falling sck
`timescale 1ns/1ps
module tss_spi_host #(
    parameter int unsigned HALF_NS = 6,
    parameter int unsigned HOLD_NS = 200
) (
    output logic sck,
    output logic chip_select_n,
    output logic mosi,
    input wire logic miso,
    input wire logic miso_oe
);
    // link clock stands still outside frames
    initial begin
        sck = 1'b0;
        chip_select_n = 1'b1;
        mosi = 1'b0;
    end

    task automatic xfer(input logic [7:0] cmd, input int nbits, output logic [15:0] rd, output logic oe);
        rd = 16'h0000;
        oe = 1'b0;
        chip_select_n = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            mosi = cmd[i];
            #(HALF_NS) sck = 1'b1;
            #(HALF_NS) sck = 1'b0;
        end
        for (int j = 0; j < nbits; j++) begin
            mosi = 1'b0;
            #(HALF_NS) sck = 1'b1;
            // an undriven line shows the inverse of the last bit, never a held value
            rd = {rd[14:0], miso_oe ? miso : ~rd[0]};
            oe = oe | miso_oe;
            #(HALF_NS) sck = 1'b0;
        end
        // select stays low so the core has time to act on the command
        #(HOLD_NS) chip_select_n = 1'b1;
        // released line: show a changing value, not the last bit
        mosi = ~mosi;
        // deselected gap, so that a following frame is always seen as a new one
        #(HOLD_NS);
    endtask
endmodule // tss_spi_host

// File: tss_readout_tb.sv
// self-checking bench for tss_readout with a serial master model
// assumes shortened refresh and self-test counts; inputs move on falling clock
`timescale 1ns/1ps
module tss_readout_tb;
    localparam int unsigned REFRESH = 50;
    localparam int unsigned SAT = 20;
    localparam int unsigned REC = 30;
    typedef struct packed {
        logic signed [11:0] x_acc;
        logic signed [11:0] y_acc;
        logic [7:0] temp;
        logic [10:0] x_exp;
        logic [10:0] y_exp;
    } tss_row_s;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic sck, chip_select_n, mosi, miso, miso_oe, nv_fetch, ctrl_fail, st_x, st_y, oe;
    logic pin_x = 1'b0;
    logic pin_y = 1'b0;
    logic signed [11:0] x_acc = 12'h000;
    logic signed [11:0] y_acc = 12'h000;
    logic [7:0] temp = 8'h00;
    logic link_ok = 1'b1;
    logic nv_par = 1'b0;
    logic [15:0] nv_word = 16'h0000;
    logic wide_sel = 1'b0;
    logic miso_w, miso_oe_w;
    logic [15:0] rd;
    int errors = 0;
    int n_tests = 0;
    int fetches = 0;
    int f0;
    tss_row_s rows [5];

    always #5 clock = ~clock;
    always @(posedge clock) if (nv_fetch === 1'b1) fetches <= fetches + 1;

    tss_readout #(.REFRESH_CYC(REFRESH), .SAT_CYC(SAT), .REC_CYC(REC), .WIDE_RANGE(1'b0)) u_dut (
        .clock(clock), .rst_n(rst_n), .sck(sck), .chip_select_n(chip_select_n), .mosi(mosi),
        .miso(miso), .miso_oe(miso_oe), .proof_mass_check_pin_x(pin_x), .proof_mass_check_pin_y(pin_y),
        .x_accel_in(x_acc), .y_accel_in(y_acc), .temp_in(temp), .element_link_ok(link_ok),
        .nv_ctrl_word(nv_word), .nv_ctrl_parity(nv_par), .nv_fetch(nv_fetch), .ctrl_fail(ctrl_fail),
        .st_drive_x(st_x), .st_drive_y(st_y));

    // wide-range twin on the same inputs; the master listens to it only while wide_sel is high
    tss_readout #(.REFRESH_CYC(REFRESH), .SAT_CYC(SAT), .REC_CYC(REC), .WIDE_RANGE(1'b1)) u_dut_wide (
        .clock(clock), .rst_n(rst_n), .sck(sck), .chip_select_n(chip_select_n), .mosi(mosi),
        .miso(miso_w), .miso_oe(miso_oe_w), .proof_mass_check_pin_x(pin_x), .proof_mass_check_pin_y(pin_y),
        .x_accel_in(x_acc), .y_accel_in(y_acc), .temp_in(temp), .element_link_ok(link_ok),
        .nv_ctrl_word(nv_word), .nv_ctrl_parity(nv_par), .nv_fetch(), .ctrl_fail(),
        .st_drive_x(), .st_drive_y());

    tss_spi_host u_host (.sck(sck), .chip_select_n(chip_select_n), .mosi(mosi), .miso(wide_sel ? miso_w : miso),
        .miso_oe(wide_sel ? miso_oe_w : miso_oe));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        if (errors == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // select high for two refresh periods so the read sees fresh data
    task automatic settle();
        repeat (2 * REFRESH + 10) @(posedge clock);
    endtask

    task automatic rd_chk(input logic [7:0] cmd, input logic [10:0] exp);
        settle();
        u_host.xfer(cmd, 11, rd, oe);
        check(rd, {5'h00, exp});
        check({15'h0000, oe}, 16'h0001);
    endtask

    task automatic fetch_reload();
        fork
            u_host.xfer(tss_pkg::CMD_RELOAD, 0, rd, oe);
            begin
                for (int k = 0; k < 60 && nv_fetch !== 1'b1; k++) @(negedge clock);
                nv_par = 1'b0;
            end
        join
        repeat (30) @(posedge clock);
    endtask

    initial begin
        rows = '{'{12'h000, 12'h000, 8'hC5, 11'h400, 11'h400}, '{12'h08F, 12'hF71, 8'h00, 11'h48F, 11'h371},
                 '{12'hF71, 12'h08F, 8'hFF, 11'h371, 11'h48F}, '{12'h830, 12'h7D0, 8'h5A, 11'h066, 11'h799},
                 '{12'h7D0, 12'h830, 8'h80, 11'h799, 11'h066}};
        repeat (12) @(posedge clock);
        @(negedge clock);
        check({13'h0000, nv_fetch, ctrl_fail, st_x | st_y}, 16'h0000);
        rst_n = 1'b1;
        for (int r = 0; r < 5; r++) begin
            @(negedge clock);
            x_acc = rows[r].x_acc;
            y_acc = rows[r].y_acc;
            temp = rows[r].temp;
            rd_chk(tss_pkg::CMD_RD_X, rows[r].x_exp);
            rd_chk(tss_pkg::CMD_RD_Y, rows[r].y_exp);
            settle();
            u_host.xfer(tss_pkg::CMD_TEMP, 11, rd, oe);
            check(rd, {5'h00, rows[r].temp, 3'h0});
            check({15'h0000, oe}, 16'h0001);
        end
        @(negedge clock);
        // five degrees on the wide variant: half the narrow deflection
        x_acc = 12'h08F;
        wide_sel = 1'b1;
        rd_chk(tss_pkg::CMD_RD_X, 11'h447);
        @(negedge clock);
        wide_sel = 1'b0;
        x_acc = 12'h000;
        y_acc = 12'h000;
        // one channel at a time, held far shorter than the real pulse limits
        for (int ch = 0; ch < 2; ch++) begin
            u_host.xfer(ch ? tss_pkg::CMD_ST_Y : tss_pkg::CMD_ST_X, 0, rd, oe);
            repeat (8) @(posedge clock);
            check({14'h0000, st_x, st_y}, ch ? 16'h0001 : 16'h0002);
            repeat (SAT) @(posedge clock);
            rd_chk(ch ? tss_pkg::CMD_RD_Y : tss_pkg::CMD_RD_X, tss_pkg::RES_ST_MAX);
            u_host.xfer(tss_pkg::CMD_MEASURE, 11, rd, oe);
            check({15'h0000, oe}, 16'h0000);
            repeat (8) @(posedge clock);
            check({14'h0000, st_x, st_y}, 16'h0000);
            repeat (REC) @(posedge clock);
            rd_chk(ch ? tss_pkg::CMD_RD_Y : tss_pkg::CMD_RD_X, tss_pkg::RES_ZERO);
            @(negedge clock);
            {pin_x, pin_y} = ch ? 2'b01 : 2'b10;
            repeat (8) @(posedge clock);
            check({14'h0000, st_x, st_y}, ch ? 16'h0001 : 16'h0002);
            @(negedge clock);
            {pin_x, pin_y} = 2'b00;
            repeat (8) @(posedge clock);
            check({14'h0000, st_x, st_y}, 16'h0000);
        end
        u_host.xfer(8'h55, 11, rd, oe);
        check({15'h0000, oe}, 16'h0000);
        @(negedge clock);
        link_ok = 1'b0;
        rd_chk(tss_pkg::CMD_RD_X, tss_pkg::RES_FAULT_HI);
        @(negedge clock);
        link_ok = 1'b1;
        // first load bad, reload good: one recovery and no failure
        @(negedge clock);
        nv_par = 1'b1;
        f0 = fetches;
        fetch_reload();
        check(16'(fetches - f0), 16'h0002);
        check({15'h0000, ctrl_fail}, 16'h0000);
        rd_chk(tss_pkg::CMD_RD_X, tss_pkg::RES_ZERO);
        // bad word stays bad after the reload: results forced low
        @(negedge clock);
        nv_par = 1'b1;
        fork
            u_host.xfer(tss_pkg::CMD_RELOAD, 0, rd, oe);
        join
        repeat (30) @(posedge clock);
        check({15'h0000, ctrl_fail}, 16'h0001);
        rd_chk(tss_pkg::CMD_RD_X, tss_pkg::RES_FAULT_LO);
        @(negedge clock);
        nv_par = 1'b0;
        rst_n = 1'b0;
        repeat (12) @(negedge clock);
        check({13'h0000, nv_fetch, ctrl_fail, st_x | st_y}, 16'h0000);
        rst_n = 1'b1;
        rd_chk(tss_pkg::CMD_RD_X, tss_pkg::RES_ZERO);
        // odd word with its parity bit set is clean; its low byte trims the offset
        @(negedge clock);
        nv_word = 16'h0001;
        nv_par = 1'b1;
        u_host.xfer(tss_pkg::CMD_RELOAD, 0, rd, oe);
        repeat (30) @(posedge clock);
        check({15'h0000, ctrl_fail}, 16'h0000);
        rd_chk(tss_pkg::CMD_RD_X, tss_pkg::RES_ZERO + 11'h001);
        results();
    end

    // whole run needs about 50 us; allow ten times that
    initial begin
        #(500000);
        errors++;
        results();
    end
endmodule // tss_readout_tb
